/* capture_src.sv */
`timescale 1ns/1ps
`default_nettype none
module capture_src (
    input  wire logic       i_clk, // Bench clock
    input  wire logic [3:0] i_go,  // Toggle request per pin
    output var  logic [3:0] o_pin  // Capture pins
);
    logic [1:0] gap_q = 2'h0;
    initial o_pin = 4'h0;
    // Requests inside the gap are dropped so no level is shorter than four clocks
    always @(posedge i_clk) begin
        if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
        else if (|i_go) begin
            o_pin <= o_pin ^ i_go;
            gap_q <= 2'h3;
        end
    end
endmodule // capture_src
`default_nettype wire

/* timer_capture_match.v */
`timescale 1ns/1ps
`default_nettype none
`include "timer_capture_match_map.vh"
// How it works
// - A 32-bit counter advances once per prescaled period of the selected count source.
// - Software chooses between counting clock cycles and counting external clock edges.
// - In event mode exactly one capture input, chosen by an index, is the count clock.
// - The other capture inputs keep working as capture channels while one is the count clock.
// - Four capture channels copy the count on a chosen input transition and may raise an interrupt.
// - A continuous match lets counting proceed and may raise an interrupt.
// - A stop match halts the counter and may raise an interrupt.
// - A reset match returns the counter to zero and may raise an interrupt.
// - Four match outputs go low, high, toggle or stay on a match, per a two-bit setting.
module timer_capture_match #(
    parameter CW = 32,                           // Counter width
    parameter NCH = 4                            // Match and capture channels
) (
    input  wire             i_clk,               // Clock, 25 MHz
    input  wire             i_sys_rst,           // Async reset, active high
    input  wire             i_enable,            // Counter enable
    input  wire             i_count_clear,       // Hold counter and prescaler at zero
    input  wire             i_mode,              // 0 timer, 1 event counter
    input  wire [1:0]       i_event_sel,         // Capture input used as count clock
    input  wire [1:0]       i_event_edge,        // Bit0 rising, bit1 falling counts
    input  wire [CW-1:0]    i_presc_limit,       // Prescaler limit
    input  wire [CW*NCH-1:0] i_match_val,        // Match values, channel 0 lowest
    input  wire [3*NCH-1:0] i_match_ctrl,        // Per channel: stop, reset, irq
    input  wire [2*NCH-1:0] i_match_act,         // Per channel output action
    input  wire [2*NCH-1:0] i_cap_edge,          // Per channel: bit0 rise, bit1 fall
    input  wire [NCH-1:0]   i_cap_irq_en,        // Capture interrupt enables
    input  wire [NCH-1:0]   i_capture_input,     // Capture pins, asynchronous
    input  wire [2*NCH-1:0] i_flag_clear,        // Clear pulses: match low, capture high
    output reg  [CW-1:0]    o_count,             // Counter value
    output reg  [CW-1:0]    o_presc,             // Prescaler value
    output reg  [CW*NCH-1:0] o_cap_val,          // Capture registers
    output reg  [NCH-1:0]   o_match_out,         // External match outputs
    output reg  [2*NCH-1:0] o_flags,             // Sticky flags: match low, capture high
    output wire             o_irq                // Interrupt request
);
    // Capture pin pipeline: two synchroniser stages and one history stage
    reg  [NCH-1:0]     sync1_q;               // First stage, may be metastable
    reg  [NCH-1:0]     sync2_q;               // Second stage, safe to decode
    reg  [NCH-1:0]     prev_q;                // Last cycle's settled level

    // Count state beside the output registers
    reg                stopped_q;             // Halted by a stop match
    reg  [CW-1:0]      count_d;               // Next counter value
    reg  [CW-1:0]      presc_d;               // Next prescaler value
    reg                stopped_d;             // Next halted state

    // Decoded events of the current cycle
    reg                src_tick;              // One tick of the count source
    reg                run_tick;              // Tick that the counter may use
    reg                at_limit;              // Prescaler sits at its limit
    reg                step;                  // Counter advances this edge
    reg  [NCH-1:0]     match_hit;             // Match seen on this step
    reg  [NCH-1:0]     cap_hit;               // Capture edge seen
    reg                do_reset;              // Some reset match fired
    reg                do_stop;               // Some stop match fired
    reg  [2*NCH-1:0]   irq_en;                // Flag enables in flag order
    reg  [NCH-1:0]     match_out_d;           // Next match pin levels
    reg  [2*NCH-1:0]   flags_d;               // Next sticky flags

    // Each loop index belongs to one process only, so no variable has two drivers
    integer            km;                    // Match decode index
    integer            kc;                    // Capture decode index
    integer            ki;                    // Interrupt enable index
    integer            ko;                    // Match output index
    integer            kv;                    // Capture register index

    // Edge test against a two-bit rise/fall select; shared by event and capture decode
    function edge_seen;
        input       now;
        input       was;
        input [1:0] sel;
        begin
            edge_seen = (sel[0] & now & ~was) | (sel[1] & ~now & was);
        end
    endfunction

    // Pin level after a match, from the two-bit action code
    function match_level;
        input       cur;
        input [1:0] act;
        begin
            case (act)
                `TCM_ACT_LOW:    match_level = 1'b0;
                `TCM_ACT_HIGH:   match_level = 1'b1;
                `TCM_ACT_TOGGLE: match_level = ~cur;
                default:         match_level = cur;
            endcase
        end
    endfunction

    // Two-flop synchroniser; only stage two feeds the history stage and the decode
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_q <= {NCH{1'b0}};
            sync2_q <= {NCH{1'b0}};
            prev_q  <= {NCH{1'b0}};
        end else begin
            sync1_q <= i_capture_input;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Count source; the pin is sampled at full rate, so the outside clock must be slow enough
    // Limitation: a level shorter than the sampling can resolve is simply not counted
    always @* begin
        if (i_mode == `TCM_MODE_TIMER)
            src_tick = 1'b1;
        else
            src_tick = edge_seen(sync2_q[i_event_sel], prev_q[i_event_sel], i_event_edge);
        run_tick = i_enable & ~stopped_q & src_tick;
        at_limit = (o_presc == i_presc_limit);
        step     = run_tick & at_limit;
    end

    // Match decode; comparing only on a step keeps a held equal count from firing again
    always @* begin
        do_reset = 1'b0;
        do_stop  = 1'b0;
        for (km = 0; km < NCH; km = km + 1) begin
            match_hit[km] = step & (o_count == i_match_val[km*CW +: CW]);
            do_reset      = do_reset | (match_hit[km] & i_match_ctrl[3*km+`TCM_MC_RESET_BIT]);
            do_stop       = do_stop  | (match_hit[km] & i_match_ctrl[3*km+`TCM_MC_STOP_BIT]);
        end
    end

    // Capture decode; the pin that clocks the counter still captures if its edge select asks for it
    always @* begin
        for (kc = 0; kc < NCH; kc = kc + 1) begin
            cap_hit[kc] = edge_seen(sync2_q[kc], prev_q[kc], i_cap_edge[2*kc +: 2]);
        end
    end

    // Interrupt enables in flag order: match channels low, capture channels high
    always @* begin
        for (ki = 0; ki < NCH; ki = ki + 1) begin
            irq_en[ki]     = i_match_ctrl[3*ki+`TCM_MC_IRQ_BIT];
            irq_en[NCH+ki] = i_cap_irq_en[ki];
        end
    end

    // Next prescaler and counter; a clear outranks counting, and a reset match zeroes the count even when a stop also fires and halts it
    always @* begin
        count_d   = o_count;
        presc_d   = o_presc;
        stopped_d = stopped_q;
        if (i_count_clear) begin
            count_d   = `TCM_COUNT_RST;
            presc_d   = `TCM_PRESC_RST;
            stopped_d = 1'b0;
        end else if (run_tick) begin
            if (at_limit) begin
                presc_d = `TCM_PRESC_RST;
                if (do_reset)
                    count_d = `TCM_COUNT_RST;
                else if (!do_stop)
                    count_d = o_count + 1'b1;
                stopped_d = do_stop;
            end else begin
                presc_d = o_presc + 1'b1;
            end
        end else if (!i_enable) begin
            // Dropping the enable releases a stop, so software restarts without a clear
            stopped_d = 1'b0;
        end
    end

    // Counter registers; all state starts at zero
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_count   <= `TCM_COUNT_RST;
            o_presc   <= `TCM_PRESC_RST;
            stopped_q <= 1'b0;
        end else begin
            o_count   <= count_d;
            o_presc   <= presc_d;
            stopped_q <= stopped_d;
        end
    end

    // Next match pin levels; a pin keeps its level unless its own channel matches
    always @* begin
        for (ko = 0; ko < NCH; ko = ko + 1) begin
            if (match_hit[ko])
                match_out_d[ko] = match_level(o_match_out[ko], i_match_act[2*ko +: 2]);
            else
                match_out_d[ko] = o_match_out[ko];
        end
    end

    // Next sticky flags; an event in the same cycle as its clear wins, so no event is lost
    always @* begin
        flags_d = (o_flags & ~i_flag_clear) | {cap_hit, match_hit};
    end

    // Capture registers take the count as it stands before this edge's step
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cap_val <= {CW*NCH{1'b0}};
        end else begin
            for (kv = 0; kv < NCH; kv = kv + 1) begin
                if (cap_hit[kv])
                    o_cap_val[kv*CW +: CW] <= o_count;
            end
        end
    end

    // Match pins and flags; the pins start low and the flags clear
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_match_out <= {NCH{1'b0}};
            o_flags     <= {2*NCH{1'b0}};
        end else begin
            o_match_out <= match_out_d;
            o_flags     <= flags_d;
        end
    end

    // Request stays up while any enabled flag is set; software clears the flag to drop it
    assign o_irq = |(o_flags & irq_en);

endmodule // timer_capture_match
`default_nettype wire

/* timer_capture_match_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_capture_match_chk #(parameter CW = 32, NCH = 4) (
    input wire logic i_clk, i_sys_rst, i_enable, i_count_clear, o_irq,
    input wire logic [CW-1:0] i_presc_limit, o_count, o_presc,
    input wire logic [CW*NCH-1:0] i_match_val,
    input wire logic [3*NCH-1:0] i_match_ctrl,
    input wire logic [2*NCH-1:0] i_match_act, o_flags,
    input wire logic [NCH-1:0] i_cap_irq_en, o_match_out);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    clr_hold_a: assert property (i_count_clear |=> o_count == 0 && o_presc == 0) else $error("clear ignored");
    count_step_a: assert property (!$stable(o_count) && !$past(i_count_clear) |->
        o_count == $past(o_count) + 1 || o_count == 0) else $error("count jumped");
    presc_wrap_a: assert property (o_count == $past(o_count) + 1 |->
        $past(o_presc) == $past(i_presc_limit) && o_presc == 0) else $error("step before limit");
    match_hit_a: assert property ($rose(o_flags[0]) |-> $past(o_count) == i_match_val[31:0]) else $error("bad match");
    reset_hit_a: assert property ($rose(o_flags[0]) && i_match_ctrl[1] |-> o_count == 0) else $error("no reset");
    stop_hit_a: assert property ($rose(o_flags[1]) && i_match_ctrl[5:4] == 2'b10 |=> $stable(o_count))
        else $error("no stop");
    out_high_a: assert property ($rose(o_flags[0]) && i_match_act[1:0] == 2'b10 |-> o_match_out[0])
        else $error("pin not high");
    irq_or_a: assert property (o_irq == |(o_flags & {i_cap_irq_en, i_match_ctrl[9], i_match_ctrl[6],
        i_match_ctrl[3], i_match_ctrl[0]})) else $error("irq wrong");
    cover property ($rose(o_flags[0]));
    cover property ($rose(o_flags[5]));
    cover property ($rose(o_irq));
endmodule // timer_capture_match_chk
bind timer_capture_match timer_capture_match_chk #(.CW(CW), .NCH(NCH)) timer_capture_match_chk_inst (.i_clk, .i_sys_rst,
    .i_enable, .i_count_clear, .o_irq, .i_presc_limit, .o_count, .o_presc, .i_match_val, .i_match_ctrl, .i_match_act,
    .o_flags, .i_cap_irq_en, .o_match_out);
`default_nettype wire

/* timer_capture_match_map.vh */
`ifndef TIMER_CAPTURE_MATCH_MAP_VH
`define TIMER_CAPTURE_MATCH_MAP_VH
// Count source select
`define TCM_MODE_TIMER      1'b0
`define TCM_MODE_EVENT      1'b1
// Match output actions, two bits per channel
`define TCM_ACT_NONE        2'b00
`define TCM_ACT_LOW         2'b01
`define TCM_ACT_HIGH        2'b10
`define TCM_ACT_TOGGLE      2'b11
// Field positions inside the three-bit per-channel match control field
`define TCM_MC_IRQ_BIT      0
`define TCM_MC_RESET_BIT    1
`define TCM_MC_STOP_BIT     2
// Reset values
`define TCM_COUNT_RST       32'h0000_0000
`define TCM_PRESC_RST       32'h0000_0000
`endif

/* timer_capture_match_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_capture_match_tb;
    logic clk = 0, rst = 1, en = 0, clr = 0, md = 0, irq;
    logic [31:0] lim = 0, cnt, ps;
    logic [1:0] es = 2'h0, ee = 2'h1;
    logic [127:0] mv = {4{32'hffff_ffff}}, cap;
    logic [11:0] mc = 0;
    logic [7:0] ma = 0, ce = 0, fc = 0, f;
    logic [3:0] ci = 0, go = 0, pins, mo;
    int miscompares = 0, samples_checked = 0, cyc = 0, i;
    capture_src capture_src_inst (.i_clk(clk), .i_go(go), .o_pin(pins));
    timer_capture_match timer_capture_match_inst (.i_clk(clk), .i_sys_rst(rst), .i_enable(en), .i_count_clear(clr),
        .i_mode(md), .i_event_sel(es), .i_event_edge(ee), .i_presc_limit(lim), .i_match_val(mv), .i_match_ctrl(mc),
        .i_match_act(ma), .i_cap_edge(ce), .i_cap_irq_en(ci), .i_capture_input(pins), .i_flag_clear(fc), .o_count(cnt),
        .o_presc(ps), .o_cap_val(cap), .o_match_out(mo), .o_flags(f), .o_irq(irq));
    initial forever #20 clk = ~clk;
    task chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task st(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait on one flag; i ends as the cycles it took
    task wf(input int b);
        for (i = 0; i < 60 && f[b] !== 1'b1; i++) st(1);
    endtask
    task results;
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Match at five with reset and output high, then flag clear
    task t_reset;
        mv[31:0] = 5; mc[2:0] = 3'b011; ma[1:0] = 2'b10; en = 1; wf(0);
        chk(i, 6); chk(cnt, 0);
        chk(mo[0], 1); chk(irq, 1);
        fc = 1; st(1); fc = 0; chk(f, 0); chk(irq, 0);
    endtask
    // Stop at three with prescaler limit two and toggling output
    task t_stop;
        en = 0; clr = 1; st(1); clr = 0; lim = 2; mv[63:32] = 3; mc[5:3] = 3'b100; ma[3:2] = 2'b11; en = 1; wf(1);
        chk(i, 12); chk(cnt, 3); chk(mo[1], 1);
        st(6); chk(cnt, 3);
        chk(ps, 0);
    endtask
    // Event counting on pin 0 while pin 1 still captures
    task t_event;
        en = 0; clr = 1; st(1); clr = 0; lim = 0; mc = 0; md = 1; ce[3:2] = 2'b01; ci = 4'h2; en = 1;
        repeat (6) begin go = 1; st(1); go = 0; st(3); end
        st(4); chk(cnt, 3);
        go = 2; st(1); go = 0; st(5);
        chk(cap[63:32], 3); chk(cnt, 3);
        chk(f, 8'h22); chk(irq, 1);
    endtask
    // Falling edges of pin 2 as count clock; continuous match drives pin 0 low, pin 1 toggles
    task t_fall;
        en = 0; clr = 1; fc = 8'hff; st(1); clr = 0; fc = 0; es = 2; ee = 2'h2; ma[1:0] = 2'b01; en = 1;
        repeat (12) begin go = 4; st(1); go = 0; st(3); end
        st(4); chk(cnt, 6);
        chk(mo, 0);
        chk(f, 8'h03); chk(irq, 0);
    endtask
    // Reset in mid-run returns every output to zero
    task t_rerst;
        rst = 1; st(2); rst = 0;
        chk(cnt, 0); chk(ps, 0); chk(mo, 0);
        chk(f, 0); chk(cap[63:32], 0);
    endtask
    // Cut a hang short
    always @(posedge clk) if (++cyc > 2000) begin miscompares++; results; end
    initial begin
        st(10); rst = 0;
        t_reset; t_stop; t_event; t_fall; t_rerst;
        results;
    end
endmodule // timer_capture_match_tb
`default_nettype wire
